// File: src/pslave_consts.svh
// Constants for the parallel slave buffer status block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef PSLAVE_CONSTS_SVH
`define PSLAVE_CONSTS_SVH

// ==========================================================
// Register offsets (word index on the register port)
`define REG_ADDR_W        3
`define REG_PORT_STATUS   3'h0
`define REG_PAD_CONFIG    3'h1
`define REG_OUT_WORD_ONE  3'h2
`define REG_OUT_WORD_TWO  3'h3
`define REG_IN_WORD_ONE   3'h4
`define REG_IN_WORD_TWO   3'h5
`define REG_IRQ_STATUS    3'h6
`define REG_IRQ_MASK      3'h7

// ==========================================================
// Port status fields
`define ST_ALL_IN_FULL    15
`define ST_IN_OVERFLOW    14
`define ST_IN_FULL_LO     8
`define ST_ALL_OUT_EMPTY  7
`define ST_OUT_UNDERFLOW  6
`define ST_OUT_EMPTY_LO   0
`define OUT_EMPTY_RESET   4'hF
`define IN_FULL_RESET     4'h0

// ==========================================================
// Pad configuration fields
`define PAD_SEC_SEL       1
`define PAD_TTL_SEL       0
`define PAD_RESET         2'h0

// ==========================================================
// Interrupt status fields
`define IRQ_HOST_WROTE    0
`define IRQ_HOST_READ     1
`define IRQ_OVERFLOW      2
`define IRQ_UNDERFLOW     3
`define IRQ_RESET         4'h0

// ==========================================================
// Misc
`define WORD_ZERO         16'h0000
`define BYTE_ZERO         8'h00
`define PIN_BUS_W         13

`endif

// File: src/pslave_pkg.sv
// Types shared by the parallel slave buffer status block.
// Assumes nothing beyond a SystemVerilog compiler.
package pslave_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [15:0] word_t;
    typedef logic [1:0]  bsel_t;
    typedef logic [3:0]  bflags_t;

    // Host access sequencer, one-hot
    typedef enum logic [2:0] {
        HOST_IDLE  = 3'b001,
        HOST_READ  = 3'b010,
        HOST_WRITE = 3'b100
    } host_state_e;

endpackage

// File: src/buf_if.sv
// Carrier between the status logic and the byte buffer memory.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface buf_if;
    import pslave_pkg::*;

    logic  sw_we;
    logic  sw_word;
    word_t sw_wdata;
    logic  sw_re;
    word_t sw_rdata;
    logic  host_we;
    logic  host_re;
    bsel_t host_sel;
    byte_t host_wdata;
    byte_t host_rdata;

    modport mem (
        input  sw_we, sw_word, sw_wdata, sw_re,
        input  host_we, host_re, host_sel, host_wdata,
        output sw_rdata, host_rdata
    );
    modport ctl (
        output sw_we, sw_word, sw_wdata, sw_re,
        output host_we, host_re, host_sel, host_wdata,
        input  sw_rdata, host_rdata
    );
endinterface

// File: src/pin_sync.sv
// Pin synchroniser: three flip-flops plus an output flip-flop, change accepted when the
// second and third agree. Assumes inputs asynchronous to clk_i.
`timescale 1ns/1ns
`include "pslave_consts.svh"
module pin_sync
    import pslave_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rstn_i,
    // Pins
    input  wire logic [`PIN_BUS_W-1:0] pins_i,
    output logic      [`PIN_BUS_W-1:0] pins_o
);
    logic [`PIN_BUS_W-1:0] s1_q;
    logic [`PIN_BUS_W-1:0] s2_q;
    logic [`PIN_BUS_W-1:0] s3_q;
    logic [`PIN_BUS_W-1:0] out_q;
    logic [`PIN_BUS_W-1:0] agree;

    assign agree  = ~(s2_q ^ s3_q);
    assign pins_o = out_q;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= pins_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= (s3_q & agree) | (out_q & ~agree);
        end
    end
endmodule // pin_sync

// File: src/byte_buffers.sv
// Four output and four input byte buffers, registered read data.
// Assumes the controller decides which writes are legal.
`timescale 1ns/1ns
`include "pslave_consts.svh"
module byte_buffers
    import pslave_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Buffer port
    buf_if.mem        bus
);
    byte_t out_q [4];
    byte_t in_q  [4];
    word_t sw_rdata_q;
    byte_t host_rdata_q;

    assign bus.sw_rdata   = sw_rdata_q;
    assign bus.host_rdata = host_rdata_q;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_byte
            localparam bit HI  = (g % 2) == 1;
            localparam bit WRD = g >= 2;
            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    out_q[g] <= `BYTE_ZERO;
                    in_q[g]  <= `BYTE_ZERO;
                end else begin
                    if (bus.sw_we && bus.sw_word == WRD) begin
                        out_q[g] <= HI ? bus.sw_wdata[15:8]
                                       : bus.sw_wdata[7:0];
                    end
                    if (bus.host_we && bus.host_sel == bsel_t'(g)) begin
                        in_q[g] <= bus.host_wdata;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sw_rdata_q   <= `WORD_ZERO;
            host_rdata_q <= `BYTE_ZERO;
        end else begin
            sw_rdata_q   <= bus.sw_re ? {in_q[{bus.sw_word, 1'b1}],
                                         in_q[{bus.sw_word, 1'b0}]}
                                      : `WORD_ZERO;
            if (bus.host_re) begin
                host_rdata_q <= out_q[bus.host_sel];
            end
        end
    end
endmodule // byte_buffers

// File: src/parallel_slave_status.sv
// Slave side of a byte-wide parallel port: buffer flags, host
// sequencing, pad configuration and clock pin routing.
// Assumes host pins asynchronous; register port on REF_CLK_I.
`timescale 1ns/1ns
`include "pslave_consts.svh"
module parallel_slave_status
    import pslave_pkg::*;
(
    // Clock and reset
    input  wire logic                   REF_CLK_I,
    input  wire logic                   RSTN_I,
    // Register port
    input  wire logic [`REG_ADDR_W-1:0] REG_ADDR_I,
    input  wire logic [15:0]            REG_WDATA_I,
    input  wire logic                   REG_WR_I,
    input  wire logic                   REG_RD_I,
    output logic      [15:0]            REG_RDATA_O,
    // Host parallel pins
    input  wire logic                   HOST_CS_I,
    input  wire logic                   HOST_RD_I,
    input  wire logic                   HOST_WR_I,
    input  wire logic [1:0]             HOST_ADDR_I,
    input  wire logic [7:0]             HOST_DATA_I,
    output logic      [7:0]             HOST_DATA_O,
    output logic                        HOST_DATA_OE_O,
    // Calendar clock pin
    input  wire logic                   SEC_CLK_I,
    input  wire logic                   ALARM_PULSE_I,
    input  wire logic                   CLK_PIN_OUT_EN_I,
    output logic                        CLK_PIN_O,
    output logic                        CLK_PIN_OE_O,
    // Pad and interrupt
    output logic                        PORT_TTL_SEL_O,
    output logic                        IRQ_O
);
    // ==========================================================
    // Decode helper
    function automatic bflags_t byte_onehot(input bsel_t sel);
        byte_onehot = bflags_t'(1) << sel;
    endfunction

    // ==========================================================
    // Host pin synchronisation
    logic [`PIN_BUS_W-1:0] pins_s;
    logic                  h_cs;
    logic                  h_rd;
    logic                  h_wr;
    bsel_t                 h_sel;
    byte_t                 h_data;

    pin_sync u_sync (
        .clk_i  (REF_CLK_I),
        .rstn_i (RSTN_I),
        .pins_i ({HOST_CS_I, HOST_RD_I, HOST_WR_I,
                  HOST_ADDR_I, HOST_DATA_I}),
        .pins_o (pins_s)
    );

    assign {h_cs, h_rd, h_wr, h_sel, h_data} = pins_s;

    // ==========================================================
    // Host access sequencer
    host_state_e state_q;
    host_state_e state_d;
    logic        host_rd_go;
    logic        host_wr_go;
    logic        strobes_off;

    assign host_rd_go  = (state_q == HOST_IDLE) && h_cs && h_rd && !h_wr;
    assign host_wr_go  = (state_q == HOST_IDLE) && h_cs && h_wr && !h_rd;
    assign strobes_off = !h_rd && !h_wr;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            HOST_IDLE: begin
                if (host_rd_go) begin
                    state_d = HOST_READ;
                end else if (host_wr_go) begin
                    state_d = HOST_WRITE;
                end
            end
            HOST_READ: begin
                if (strobes_off || !h_cs) begin
                    state_d = HOST_IDLE;
                end
            end
            HOST_WRITE: begin
                if (strobes_off || !h_cs) begin
                    state_d = HOST_IDLE;
                end
            end
            default: begin
                state_d = HOST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Register port decode
    logic wr_status;
    logic wr_pad;
    logic wr_out_one;
    logic wr_out_two;
    logic rd_in_one;
    logic rd_in_two;
    logic wr_irq_st;
    logic wr_irq_mask;

    assign wr_status   = REG_WR_I && REG_ADDR_I == `REG_PORT_STATUS;
    assign wr_pad      = REG_WR_I && REG_ADDR_I == `REG_PAD_CONFIG;
    assign wr_out_one  = REG_WR_I && REG_ADDR_I == `REG_OUT_WORD_ONE;
    assign wr_out_two  = REG_WR_I && REG_ADDR_I == `REG_OUT_WORD_TWO;
    assign rd_in_one   = REG_RD_I && REG_ADDR_I == `REG_IN_WORD_ONE;
    assign rd_in_two   = REG_RD_I && REG_ADDR_I == `REG_IN_WORD_TWO;
    assign wr_irq_st   = REG_WR_I && REG_ADDR_I == `REG_IRQ_STATUS;
    assign wr_irq_mask = REG_WR_I && REG_ADDR_I == `REG_IRQ_MASK;

    // ==========================================================
    // Buffer flags
    bflags_t ob_empty_q;
    bflags_t ob_empty_d;
    bflags_t ib_full_q;
    bflags_t ib_full_d;
    bflags_t h_oh;
    bflags_t sw_fill;
    bflags_t sw_drain;
    bflags_t in_write;
    logic    ovf_q;
    logic    ovf_d;
    logic    unf_q;
    logic    unf_d;
    logic    ovf_evt;
    logic    unf_evt;
    logic    host_we;

    assign h_oh     = byte_onehot(h_sel);
    assign sw_fill  = {{2{wr_out_two}}, {2{wr_out_one}}};
    assign sw_drain = {{2{rd_in_two}}, {2{rd_in_one}}};

    assign unf_evt  = host_rd_go && |(h_oh & ob_empty_q);
    assign ovf_evt  = host_wr_go && |(h_oh & ib_full_q);
    // Overrun data is dropped so the unread byte survives
    assign host_we  = host_wr_go && !ovf_evt;
    assign in_write = host_we ? h_oh : '0;

    // A new software fill wins over a host read in the same cycle
    assign ob_empty_d = (ob_empty_q | (host_rd_go ? h_oh : '0))
                      & ~sw_fill;
    assign ib_full_d  = (ib_full_q & ~sw_drain) | in_write;

    // Writing zero clears; the hardware set wins the same cycle
    assign unf_d = unf_evt
                 || (unf_q && !(wr_status
                              && !REG_WDATA_I[`ST_OUT_UNDERFLOW]));
    assign ovf_d = ovf_evt
                 || (ovf_q && !(wr_status
                              && !REG_WDATA_I[`ST_IN_OVERFLOW]));

    // ==========================================================
    // Buffer memory
    buf_if bufs ();

    assign bufs.sw_we      = wr_out_one || wr_out_two;
    assign bufs.sw_word    = wr_out_two || rd_in_two;
    assign bufs.sw_wdata   = REG_WDATA_I;
    assign bufs.sw_re      = rd_in_one || rd_in_two;
    assign bufs.host_we    = host_we;
    assign bufs.host_re    = host_rd_go;
    assign bufs.host_sel   = h_sel;
    assign bufs.host_wdata = h_data;

    byte_buffers u_bufs (
        .clk_i  (REF_CLK_I),
        .rstn_i (RSTN_I),
        .bus    (bufs.mem)
    );

    // ==========================================================
    // Configuration and interrupts
    logic [1:0] pad_q;
    bflags_t    irq_st_q;
    bflags_t    irq_st_d;
    bflags_t    irq_mask_q;
    bflags_t    irq_evt;

    assign irq_evt[`IRQ_HOST_WROTE] = host_we;
    assign irq_evt[`IRQ_HOST_READ]  = host_rd_go;
    assign irq_evt[`IRQ_OVERFLOW]   = ovf_evt;
    assign irq_evt[`IRQ_UNDERFLOW]  = unf_evt;
    assign irq_st_d = irq_evt
                    | (irq_st_q & ~(wr_irq_st ? REG_WDATA_I[3:0] : '0));

    // ==========================================================
    // Read data
    word_t status_word;
    word_t rdata_d;
    word_t rdata_q;
    logic  rd_mem_q;

    assign status_word = {&ib_full_q, ovf_q, 2'b00, ib_full_q,
                          &ob_empty_q, unf_q, 2'b00, ob_empty_q};

    always_comb begin
        rdata_d = `WORD_ZERO;
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                `REG_PORT_STATUS: rdata_d = status_word;
                `REG_PAD_CONFIG:  rdata_d = {14'h0000, pad_q};
                `REG_IRQ_STATUS:  rdata_d = {12'h000, irq_st_q};
                `REG_IRQ_MASK:    rdata_d = {12'h000, irq_mask_q};
                default:          rdata_d = `WORD_ZERO;
            endcase
        end
    end

    assign REG_RDATA_O = rd_mem_q ? bufs.sw_rdata : rdata_q;

    // ==========================================================
    // State registers
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            state_q    <= HOST_IDLE;
            ob_empty_q <= `OUT_EMPTY_RESET;
            ib_full_q  <= `IN_FULL_RESET;
            ovf_q      <= 1'b0;
            unf_q      <= 1'b0;
            pad_q      <= `PAD_RESET;
            irq_st_q   <= `IRQ_RESET;
            irq_mask_q <= `IRQ_RESET;
            rdata_q    <= `WORD_ZERO;
            rd_mem_q   <= 1'b0;
        end else begin
            state_q    <= state_d;
            ob_empty_q <= ob_empty_d;
            ib_full_q  <= ib_full_d;
            ovf_q      <= ovf_d;
            unf_q      <= unf_d;
            if (wr_pad) begin
                pad_q  <= REG_WDATA_I[1:0];
            end
            irq_st_q   <= irq_st_d;
            if (wr_irq_mask) begin
                irq_mask_q <= REG_WDATA_I[3:0];
            end
            rdata_q    <= rdata_d;
            rd_mem_q   <= rd_in_one || rd_in_two;
        end
    end

    // ==========================================================
    // Pins
    logic clk_pin_q;
    logic clk_oe_q;

    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            clk_pin_q <= 1'b0;
            clk_oe_q  <= 1'b0;
        end else begin
            clk_oe_q  <= CLK_PIN_OUT_EN_I;
            clk_pin_q <= CLK_PIN_OUT_EN_I
                       && (pad_q[`PAD_SEC_SEL] ? SEC_CLK_I
                                               : ALARM_PULSE_I);
        end
    end

    assign CLK_PIN_O      = clk_pin_q;
    assign CLK_PIN_OE_O   = clk_oe_q;
    assign PORT_TTL_SEL_O = pad_q[`PAD_TTL_SEL];
    assign HOST_DATA_O    = bufs.host_rdata;
    assign HOST_DATA_OE_O = state_q == HOST_READ;
    assign IRQ_O          = |(irq_st_q & irq_mask_q);
endmodule // parallel_slave_status

// File: verification/pslave_monitor.sv
// Checker for the parallel slave block, bound to its top ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`include "pslave_consts.svh"
module pslave_monitor (
    // Clock and reset
    input wire logic                   REF_CLK_I,
    input wire logic                   RSTN_I,
    // Register port
    input wire logic [`REG_ADDR_W-1:0] REG_ADDR_I,
    input wire logic [15:0]            REG_WDATA_I,
    input wire logic                   REG_WR_I,
    input wire logic                   REG_RD_I,
    input wire logic [15:0]            REG_RDATA_O,
    // Pins
    input wire logic                   HOST_RD_I,
    input wire logic                   HOST_DATA_OE_O,
    input wire logic                   SEC_CLK_I,
    input wire logic                   ALARM_PULSE_I,
    input wire logic                   CLK_PIN_OUT_EN_I,
    input wire logic                   CLK_PIN_O,
    input wire logic                   CLK_PIN_OE_O,
    input wire logic                   PORT_TTL_SEL_O,
    input wire logic                   IRQ_O
);
    // ==========
    // Shadow of pad bits and of sticky flags seen set
    logic        sel_q, sel_d, ttl_q, ttl_d, st_rd_q, st_rd;
    logic        pad_wr, st_wr, mask_wr, src;
    logic [1:0]  fl_q, fl_d, seen;
    logic [15:0] pad_v;
    assign pad_wr  = REG_WR_I && REG_ADDR_I == `REG_PAD_CONFIG;
    assign st_wr   = REG_WR_I && REG_ADDR_I == `REG_PORT_STATUS;
    assign st_rd   = REG_RD_I && REG_ADDR_I == `REG_PORT_STATUS;
    assign mask_wr = REG_WR_I && REG_ADDR_I == `REG_IRQ_MASK;
    assign sel_d   = pad_wr ? REG_WDATA_I[`PAD_SEC_SEL] : sel_q;
    assign ttl_d   = pad_wr ? REG_WDATA_I[`PAD_TTL_SEL] : ttl_q;
    assign src     = sel_q ? SEC_CLK_I : ALARM_PULSE_I;
    assign pad_v   = {14'h0000, sel_q, ttl_q};
    assign seen    = st_rd_q ? {REG_RDATA_O[14], REG_RDATA_O[6]} : 2'b00;
    // Writing a zero clears; a one leaves the flag alone
    assign fl_d    = (fl_q | seen)
                   & (st_wr ? {REG_WDATA_I[14], REG_WDATA_I[6]} : 2'b11);
    always_ff @(posedge REF_CLK_I) begin
        if (!RSTN_I) begin
            sel_q   <= 1'b0;
            ttl_q   <= 1'b0;
            st_rd_q <= 1'b0;
            fl_q    <= 2'b00;
        end else begin
            sel_q   <= sel_d;
            ttl_q   <= ttl_d;
            st_rd_q <= st_rd;
            fl_q    <= fl_d;
        end
    end

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RSTN_I);

    // ==========
    // Properties
    property p_rd_idle;
        !REG_RD_I |=> REG_RDATA_O == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read");
    property p_pad_rd;
        REG_RD_I && REG_ADDR_I == `REG_PAD_CONFIG
            |=> REG_RDATA_O == $past(pad_v);
    endproperty
    a_pad_rd: assert property (p_pad_rd)
        else $error("pad register read wrong");
    property p_ttl;
        1'b1 |-> PORT_TTL_SEL_O == ttl_q;
    endproperty
    a_ttl: assert property (p_ttl)
        else $error("buffer type output wrong");
    property p_clk_src;
        CLK_PIN_OUT_EN_I |=> CLK_PIN_OE_O && CLK_PIN_O == $past(src);
    endproperty
    a_clk_src: assert property (p_clk_src)
        else $error("clock pin source wrong");
    property p_clk_off;
        !CLK_PIN_OUT_EN_I |=> !CLK_PIN_O && !CLK_PIN_OE_O;
    endproperty
    a_clk_off: assert property (p_clk_off)
        else $error("clock pin active while disabled");
    property p_ovf_hold;
        st_rd_q && fl_q[1] |-> REG_RDATA_O[14];
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow flag dropped without a write");
    property p_unf_hold;
        st_rd_q && fl_q[0] |-> REG_RDATA_O[6];
    endproperty
    a_unf_hold: assert property (p_unf_hold)
        else $error("underflow flag dropped without a write");
    property p_irq_off;
        mask_wr && REG_WDATA_I[3:0] == 4'h0 ##1 !mask_wr |-> ##1 !IRQ_O;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt high with all masked");
    property p_oe_rd;
        $rose(HOST_DATA_OE_O) |-> $past(HOST_RD_I, 2);
    endproperty
    a_oe_rd: assert property (p_oe_rd)
        else $error("data bus driven without a host read");
endmodule // pslave_monitor

bind parallel_slave_status pslave_monitor pslave_monitor_i (
    .REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .HOST_RD_I(HOST_RD_I),
    .HOST_DATA_OE_O(HOST_DATA_OE_O), .SEC_CLK_I(SEC_CLK_I),
    .ALARM_PULSE_I(ALARM_PULSE_I), .CLK_PIN_OUT_EN_I(CLK_PIN_OUT_EN_I),
    .CLK_PIN_O(CLK_PIN_O), .CLK_PIN_OE_O(CLK_PIN_OE_O),
    .PORT_TTL_SEL_O(PORT_TTL_SEL_O), .IRQ_O(IRQ_O)
);

// File: verification/host_model.sv
// External host on the byte-wide slave pins.
// Assumes the caller enters its task right after a rising edge.
`timescale 1ns/1ns
module host_model
    import pslave_pkg::*;
(
    // Clock
    input  wire logic  clk_i,
    // Pins toward the block
    output logic       cs_o,
    output logic       rd_o,
    output logic       wr_o,
    output bsel_t      addr_o,
    output byte_t      data_o,
    // Answer from the block
    input  wire byte_t rdata_i,
    input  wire logic  oe_i
);
    initial begin
        cs_o   = 1'b0;
        rd_o   = 1'b0;
        wr_o   = 1'b0;
        addr_o = 2'h0;
        data_o = 8'h00;
    end
    // ==========
    // One byte per strobe; a read is held until the block drives, at most 20 cycles past hold
    task automatic access(input logic w, input bsel_t a, input byte_t d,
                          input int hold, output byte_t q);
        int n;
        n = 0;
        cs_o   <= 1'b1;
        rd_o   <= !w;
        wr_o   <= w;
        addr_o <= a;
        data_o <= w ? d : ~data_o;
        repeat (hold) @(posedge clk_i);
        while (!w && !oe_i && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        // A read the block never answers must not match
        q = (w || oe_i) ? rdata_i : ~rdata_i;
        cs_o   <= 1'b0;
        rd_o   <= 1'b0;
        wr_o   <= 1'b0;
        // Released bus never keeps the last byte
        data_o <= ~data_o;
        repeat (6) @(posedge clk_i);
    endtask
endmodule // host_model

// File: verification/tb_top.sv
// Self-checking bench for the parallel slave block.
// Assumes the checker is bound in and the host model drives the pins.
`timescale 1ns/1ns
`include "pslave_consts.svh"
module tb_top;
    import pslave_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [2:0]  addr = 3'h0;
    word_t       wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        sec = 1'b0;
    logic        alarm = 1'b0;
    logic        en = 1'b0;
    word_t       rdata, q, w1, w2, v;
    logic        cs, hrd, hwr, hoe, pin, pin_oe, ttl, irq;
    bsel_t       haddr;
    byte_t       hdin, hdout, hb;
    byte_t       b [4];
    logic [31:0] ow;
    word_t       rnd = 16'h0016;
    int          fails = 0;
    int          checks_done = 0;

    always #10 clk = ~clk;

    parallel_slave_status parallel_slave_status_i (
        .REF_CLK_I(clk), .RSTN_I(rstn), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .HOST_CS_I(cs), .HOST_RD_I(hrd),
        .HOST_WR_I(hwr), .HOST_ADDR_I(haddr), .HOST_DATA_I(hdin),
        .HOST_DATA_O(hdout), .HOST_DATA_OE_O(hoe), .SEC_CLK_I(sec),
        .ALARM_PULSE_I(alarm), .CLK_PIN_OUT_EN_I(en), .CLK_PIN_O(pin),
        .CLK_PIN_OE_O(pin_oe), .PORT_TTL_SEL_O(ttl), .IRQ_O(irq));
    host_model host_model_i (
        .clk_i(clk), .cs_o(cs), .rd_o(hrd), .wr_o(hwr), .addr_o(haddr),
        .data_o(hdin), .rdata_i(hdout), .oe_i(hoe));

    // ==========
    // Helpers
    function automatic word_t lfsr(input word_t s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input word_t seen, input word_t exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input word_t d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask
    task automatic reg_rd(input logic [2:0] a, output word_t d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic stop_test;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        stop_test();
    end

    // ==========
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        reg_rd(`REG_PORT_STATUS, q);
        chk(q, 16'h008f);
        chk({15'h0000, ttl}, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            v = (i == 0) ? 16'hffff : rnd;
            en    <= v[4];
            sec   <= v[5];
            alarm <= v[6];
            reg_wr(`REG_PAD_CONFIG, v);
            reg_rd(`REG_PAD_CONFIG, q);
            chk(q, {14'h0000, v[1:0]});
            chk({15'h0000, ttl}, {15'h0000, v[0]});
            hb = {7'h00, v[4] & (v[1] ? v[5] : v[6])};
            chk({15'h0000, pin}, {8'h00, hb});
            chk({15'h0000, pin_oe}, {15'h0000, v[4]});
        end
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            b[i] = rnd[7:0];
            host_model_i.access(1'b1, i[1:0], b[i], 6 + i, hb);
        end
        reg_rd(`REG_PORT_STATUS, q);
        chk(q, 16'h8f8f);
        host_model_i.access(1'b1, 2'b10, ~b[2], 6, hb);
        reg_rd(`REG_PORT_STATUS, q);
        chk(q, 16'hcf8f);
        reg_rd(`REG_IN_WORD_ONE, q);
        chk(q, {b[1], b[0]});
        reg_rd(`REG_IN_WORD_TWO, q);
        chk(q, {b[3], b[2]});
        reg_rd(`REG_PORT_STATUS, q);
        chk(q, 16'h408f);
        reg_wr(`REG_PORT_STATUS, 16'h0000);
        reg_rd(`REG_PORT_STATUS, q);
        chk(q, 16'h008f);
        w1 = lfsr(rnd);
        w2 = lfsr(w1);
        ow = {w2, w1};
        reg_wr(`REG_OUT_WORD_ONE, w1);
        reg_wr(`REG_OUT_WORD_TWO, w2);
        reg_rd(`REG_PORT_STATUS, q);
        chk(q, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            host_model_i.access(1'b0, i[1:0], 8'h00, 6 + 2 * i, hb);
            chk({8'h00, hb}, {8'h00, ow[8 * i +: 8]});
        end
        host_model_i.access(1'b0, 2'b01, 8'h00, 6, hb);
        reg_rd(`REG_PORT_STATUS, q);
        chk(q, 16'h00cf);
        // Writing a one must not clear the flag
        reg_wr(`REG_PORT_STATUS, 16'h4040);
        reg_rd(`REG_PORT_STATUS, q);
        chk(q, 16'h00cf);
        reg_wr(`REG_PORT_STATUS, 16'h0000);
        reg_rd(`REG_PORT_STATUS, q);
        chk(q, 16'h008f);
        chk({15'h0000, irq}, 16'h0000);
        reg_rd(`REG_IRQ_STATUS, q);
        chk(q, 16'h000f);
        reg_wr(`REG_IRQ_MASK, 16'h0004);
        @(posedge clk);
        chk({15'h0000, irq}, 16'h0001);
        reg_wr(`REG_IRQ_STATUS, 16'h0004);
        @(posedge clk);
        chk({15'h0000, irq}, 16'h0000);
        reg_rd(`REG_IRQ_STATUS, q);
        chk(q, 16'h000b);
        reg_wr(`REG_IRQ_MASK, 16'h0000);
        repeat (3) @(posedge clk);
        stop_test();
    end
endmodule // tb_top
